// file: count_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module count_prescaler (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       clr_i,
  input  wire logic       evt_i,
  input  wire logic       lvl_i,
  input  wire logic [1:0] ratio_i,
  output logic            pulse_o,
  output logic            level_o
);

  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [2:0] mask;

  // Ones in the low bits that must be full before a pulse
  function automatic logic [2:0] ratio_mask(input logic [1:0] r);
    ratio_mask = 3'h0;
    if (r == 2'h1) ratio_mask = 3'h1;
    else if (r == 2'h2) ratio_mask = 3'h3;
    else if (r == 2'h3) ratio_mask = 3'h7;
  endfunction

  // ==========================================================
  // Divide chain: 1:1, 1:2, 1:4, 1:8
  always_comb begin
    mask     = ratio_mask(ratio_i);
    next_cnt = cnt;
    if (clr_i) next_cnt = timer_one_pkg::PRESC_RESET;
    else if (evt_i) next_cnt = cnt + 3'h1;
    pulse_o = evt_i && !clr_i && ((cnt & mask) == mask);
    // Symmetric level output for the resynchronising path
    if (ratio_i == 2'h0) level_o = lvl_i;
    else level_o = cnt[ratio_i - 2'h1];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) cnt <= timer_one_pkg::PRESC_RESET;
    else cnt <= next_cnt;
  end

endmodule
`default_nettype wire

// file: pin_source.sv
`timescale 1ns/100ps
`default_nettype none
// Outside a burst both pins stand still low
module pin_source (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic       pick_i,
  input  wire logic [5:0] count_i,
  output logic            osc_pin_o,
  output logic            clk_pin_o,
  output logic            busy_o
);
  logic [5:0] left;
  logic [3:0] ph;
  // Six cycles high, six low: wide enough for two-flop sampling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left <= 6'h00;
      ph   <= 4'h0;
    end else if (start_i && left == 6'h00) begin
      left <= count_i;
      ph   <= 4'h0;
    end else if (left != 6'h00) begin
      ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
      if (ph == 4'hB) begin
        left <= left - 6'h01;
      end
    end
  end
  // Edges on the chosen pin only
  assign osc_pin_o = pick_i && left != 6'h00 && ph < 4'h6;
  assign clk_pin_o = !pick_i && left != 6'h00 && ph < 4'h6;
  assign busy_o    = left != 6'h00;
endmodule
`default_nettype wire

// file: sixteen_bit_timer_counter.sv
// Overview of operation
// - Count is sixteen bits, two byte registers, both readable and writable.
// - Counts up from 0000h to FFFFh, then wraps to zero.
// - Wrap from maximum latches the overflow flag until software clears it.
// - Interrupt request passes only while the enable bit is set.
// - Source select bit: one counts pin edges, zero the instruction clock.
// - Timer mode steps once per prescaled instruction cycle; sync bit has no effect.
// - Counter mode steps once per prescaled rising edge of the pin.
// - On bit lets counting happen; cleared, the count stays frozen.
// - Prescale field picks 1:1, 1:2, 1:4 or 1:8.
// - Oscillator enable bit runs the low-power oscillator or shuts it off.
// - With external source, sync bit set skips synchronising, clear uses it.
// - Internal source ignores the sync bit entirely.
// - Reset input from either compare unit clears the count.
// - Oscillator enabled forces both oscillator pins to inputs.
// - Control bits 7 and 6 ignore writes and read as zero.
// - Counter mode uses oscillator pin if enabled, else clock pin.
// - Sync-mode resynchronising happens after the prescaler; both pins are also two-flop synchronised before it.
// - Compare-unit reset never sets the overflow flag.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
`default_nettype none
module sixteen_bit_timer_counter #(
  parameter bit FORCE_BOTH_PINS = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [1:0]  cmp_reset_i,
  input  wire logic        osc_input_pin_i,
  output logic             osc_input_pin_o,
  output logic             osc_input_pin_oe_n_o,
  input  wire logic        count_clock_pin_i,
  output logic             count_clock_pin_o,
  output logic             count_clock_pin_oe_n_o,
  output logic             osc_run_o,
  output logic             irq_o
);

  // ==========================================================
  // State
  logic [7:0]  control;
  logic [15:0] wide_count;
  logic        overflow_flag;
  logic        overflow_irq_enable;
  logic [7:0]  port_reg;
  // Core clocks within the current instruction cycle
  logic [1:0]  instr_cnt;
  logic        ext_prev;
  logic        lvl_prev;

  // Next values, one for each register above and one for each output flop except the two pin data flops
  logic [7:0]  next_control;
  logic [15:0] next_count;
  logic        next_flag;
  logic        next_irq_enable;
  logic [7:0]  next_port;
  logic [1:0]  next_instr_cnt;
  logic        next_ext_prev;
  logic        next_lvl_prev;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        next_irq;
  logic        next_osc_run;
  logic        next_osc_in_oe_n;
  logic        next_clk_pin_oe_n;

  // ==========================================================
  // Decoded control fields
  logic       counter_on;
  logic       source_select;
  logic       sync_disable;
  logic       osc_enable;
  logic [1:0] prescale_field;

  // Bits 7:6 never reach the register, so they always read back as zero
  assign counter_on     = control[timer_one_pkg::CTL_ON_BIT];
  assign source_select  = control[timer_one_pkg::CTL_SRC_BIT];
  assign sync_disable   = control[timer_one_pkg::CTL_SYNC_BIT];
  assign osc_enable     = control[timer_one_pkg::CTL_OSC_BIT];
  assign prescale_field = control[timer_one_pkg::CTL_PS_LSB +: 2];

  // ==========================================================
  // Bus request decode
  logic req;
  logic wr;
  logic wr_ctl;
  logic wr_low;
  logic wr_high;
  logic wr_flag;
  logic wr_en;
  logic wr_port;

  // Only byte lane 0 carries data; a write with that lane off is acked and dropped
  // Address must hold while the request stands, or the strobe lands elsewhere
  // One answer per request; the cycle in which ack is high takes no request, which blocks a repeat
  assign req     = cyc_i && stb_i && !ack_o;
  assign wr      = req && we_i && sel_i[0];
  assign wr_ctl  = wr && (adr_i == timer_one_pkg::CONTROL_OFFSET);
  assign wr_low  = wr && (adr_i == timer_one_pkg::COUNT_LOW_OFFSET);
  assign wr_high = wr && (adr_i == timer_one_pkg::COUNT_HIGH_OFFSET);
  assign wr_flag = wr && (adr_i == timer_one_pkg::FLAG_OFFSET);
  assign wr_en   = wr && (adr_i == timer_one_pkg::ENABLE_OFFSET);
  assign wr_port = wr && (adr_i == timer_one_pkg::PORT_OFFSET);

  // ==========================================================
  // Pin inputs: two flops before anything looks at them
  // Both pins are asynchronous; the second flop gives the first a cycle to settle
  logic [1:0] pin_s;

  sync_two_flop #(
    .WIDTH (2)
  ) pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({count_clock_pin_i, osc_input_pin_i}),
    .q_o   (pin_s)
  );

  // ==========================================================
  // Count source and prescaler
  logic ext_level;
  logic ext_rise;
  logic instr_tick;
  logic presc_evt;
  logic presc_clr;
  logic presc_pulse;
  logic presc_level;
  logic cmp_reset;

  // A pin pulse shorter than one clock can slip between samples and be lost
  // Oscillator pin carries the edges when the oscillator runs
  assign ext_level  = osc_enable ? pin_s[0] : pin_s[1];
  assign ext_rise   = ext_level && !ext_prev;
  assign instr_tick = (instr_cnt == timer_one_pkg::INSTR_LAST);
  // Stopped timer also holds the prescaler still
  assign presc_evt  = counter_on && (source_select ? ext_rise : instr_tick);
  assign cmp_reset  = |cmp_reset_i;
  // Any count write or compare reset restarts the prescaler from zero
  assign presc_clr  = cmp_reset || wr_low || wr_high;

  count_prescaler presc (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clr_i   (presc_clr),
    .evt_i   (presc_evt),
    .lvl_i   (ext_level),
    .ratio_i (prescale_field),
    .pulse_o (presc_pulse),
    .level_o (presc_level)
  );

  // ==========================================================
  // Resynchronising after the prescaler, as the sync mode does
  logic lvl_s;
  logic sync_rise;

  sync_two_flop #(
    .WIDTH (1)
  ) lvl_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (presc_level),
    .q_o   (lvl_s)
  );

  // Two cycles of extra latency buy a clean edge from a level
  assign sync_rise = lvl_s && !lvl_prev;

  // ==========================================================
  // Increment select
  logic inc;
  logic overflow;

  // Async mode counts the prescaler pulse directly, two cycles sooner at 1:1
  // Unsynchronised mode skips two flops of latency; the sync bit is
  // consulted only for the external source
  always_comb begin
    inc = 1'b0;
    if (counter_on) begin
      if (!source_select) inc = presc_pulse;
      else if (sync_disable) inc = presc_pulse;
      else inc = sync_rise;
    end
  end

  // Trade-off: a wrap that meets a load or compare reset is dropped, not half-seen
  // A loaded or reset count never reports a wrap
  assign overflow = inc && (wide_count == timer_one_pkg::COUNT_MAX)
                    && !cmp_reset && !wr_low && !wr_high;

  // ==========================================================
  // Count, flag and register next values
  always_comb begin
    next_instr_cnt = instr_cnt + 2'h1;
    next_ext_prev  = ext_level;
    next_lvl_prev  = lvl_s;
    // Later lines win: increment, then compare reset, then byte writes
    next_count     = wide_count;
    if (inc) next_count = wide_count + 16'h0001;
    if (cmp_reset) next_count = timer_one_pkg::COUNT_RESET;
    if (wr_low) next_count[7:0] = dat_i[7:0];
    if (wr_high) next_count[15:8] = dat_i[7:0];
    next_flag = overflow_flag;
    if (wr_flag) next_flag = dat_i[timer_one_pkg::FLAG_BIT];
    // Set beats a same-cycle clear
    if (overflow) next_flag = 1'b1;
    next_control = control;
    if (wr_ctl) next_control = dat_i[7:0] & timer_one_pkg::CTL_IMPL_MASK;
    next_irq_enable = overflow_irq_enable;
    if (wr_en) next_irq_enable = dat_i[timer_one_pkg::IRQEN_BIT];
    next_port = port_reg;
    if (wr_port) next_port = dat_i[7:0];
  end

  // ==========================================================
  // Outputs, all from flops
  always_comb begin
    // Built from next values so each output flop lands with its register
    next_ack     = req;
    next_irq     = next_flag && next_irq_enable;
    next_osc_run = next_control[timer_one_pkg::CTL_OSC_BIT];
    // Its direction bit or a running oscillator makes the pin an input
    next_osc_in_oe_n = next_port[timer_one_pkg::PORT_DIR_LSB]
                       || next_osc_run;
    next_clk_pin_oe_n = next_port[timer_one_pkg::PORT_DIR_LSB + 1];
    // Older parts leave the clock pin to its direction bit
    if (FORCE_BOTH_PINS && next_osc_run) next_clk_pin_oe_n = 1'b1;
  end

  // ==========================================================
  // Read data mux; unmapped addresses answer zero
  // No latch between the bytes: a running count may tear across two reads
  always_comb begin
    next_dat = timer_one_pkg::BUS_ZERO;
    if (!req || we_i) begin
      next_dat = timer_one_pkg::BUS_ZERO;
    end else if (adr_i == timer_one_pkg::CONTROL_OFFSET) begin
      next_dat[7:0] = control & timer_one_pkg::CTL_IMPL_MASK;
    end else if (adr_i == timer_one_pkg::COUNT_LOW_OFFSET) begin
      next_dat[7:0] = wide_count[7:0];
    end else if (adr_i == timer_one_pkg::COUNT_HIGH_OFFSET) begin
      next_dat[7:0] = wide_count[15:8];
    end else if (adr_i == timer_one_pkg::FLAG_OFFSET) begin
      next_dat[timer_one_pkg::FLAG_BIT] = overflow_flag;
    end else if (adr_i == timer_one_pkg::ENABLE_OFFSET) begin
      next_dat[timer_one_pkg::IRQEN_BIT] = overflow_irq_enable;
    end else if (adr_i == timer_one_pkg::PORT_OFFSET) begin
      next_dat[7:0] = port_reg;
    end
  end

  // ==========================================================
  // Register update
  // Reset leaves both pins as inputs and the timer stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control                <= timer_one_pkg::CONTROL_RESET;
      wide_count             <= timer_one_pkg::COUNT_RESET;
      overflow_flag          <= 1'b0;
      overflow_irq_enable    <= 1'b0;
      port_reg               <= timer_one_pkg::PORT_RESET;
      instr_cnt              <= 2'h0;
      ext_prev               <= 1'b0;
      lvl_prev               <= 1'b0;
      dat_o                  <= timer_one_pkg::BUS_ZERO;
      ack_o                  <= 1'b0;
      irq_o                  <= 1'b0;
      osc_run_o              <= 1'b0;
      osc_input_pin_o        <= 1'b0;
      osc_input_pin_oe_n_o   <= 1'b1;
      count_clock_pin_o      <= 1'b0;
      count_clock_pin_oe_n_o <= 1'b1;
    end else begin
      control                <= next_control;
      wide_count             <= next_count;
      overflow_flag          <= next_flag;
      overflow_irq_enable    <= next_irq_enable;
      port_reg               <= next_port;
      instr_cnt              <= next_instr_cnt;
      ext_prev               <= next_ext_prev;
      lvl_prev               <= next_lvl_prev;
      dat_o                  <= next_dat;
      ack_o                  <= next_ack;
      irq_o                  <= next_irq;
      osc_run_o              <= next_osc_run;
      // Pin data follows the port register; oe_n decides whether it drives
      osc_input_pin_o        <= next_port[timer_one_pkg::PORT_OUT_LSB];
      osc_input_pin_oe_n_o   <= next_osc_in_oe_n;
      count_clock_pin_o      <= next_port[timer_one_pkg::PORT_OUT_LSB + 1];
      count_clock_pin_oe_n_o <= next_clk_pin_oe_n;
    end
  end

endmodule
`default_nettype wire

// file: sixteen_bit_timer_counter_test.sv
`timescale 1ns/100ps
`default_nettype none
module sixteen_bit_timer_counter_test;
  localparam logic [7:0] CTL = timer_one_pkg::CONTROL_OFFSET;
  localparam logic [7:0] LO  = timer_one_pkg::COUNT_LOW_OFFSET;
  localparam logic [7:0] HI  = timer_one_pkg::COUNT_HIGH_OFFSET;
  localparam logic [7:0] FLG = timer_one_pkg::FLAG_OFFSET;
  localparam logic [7:0] IEN = timer_one_pkg::ENABLE_OFFSET;
  localparam logic [7:0] PRT = timer_one_pkg::PORT_OFFSET;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, p_start = 0, p_pick = 0;
  logic [7:0]  adr = 8'h00, q;
  logic [31:0] wdat = 32'h0000_0000, seed = 32'h0000_1905, r;
  logic [1:0]  cmp = 2'h0;
  logic [3:0]  sel = 4'h1;
  logic [5:0]  p_cnt = 6'h00;
  logic [15:0] v;
  wire logic [31:0] rdat;
  wire logic ack, osc_o, osc_oe_n, ck_o, ck_oe_n, run, irq, p_osc, p_ck, p_busy;
  int failures = 0, samples_checked = 0;
  // Pin level: the device wins while it drives
  wire logic osc_pin = osc_oe_n ? p_osc : osc_o;
  wire logic ck_pin  = ck_oe_n ? p_ck : ck_o;

  initial forever #2.5 clk_i = ~clk_i;

  sixteen_bit_timer_counter i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .cmp_reset_i(cmp), .osc_input_pin_i(osc_pin), .osc_input_pin_o(osc_o),
    .osc_input_pin_oe_n_o(osc_oe_n), .count_clock_pin_i(ck_pin), .count_clock_pin_o(ck_o),
    .count_clock_pin_oe_n_o(ck_oe_n), .osc_run_o(run), .irq_o(irq));
  pin_source i_src (.clk_i(clk_i), .rst_i(rst_i), .start_i(p_start), .pick_i(p_pick),
    .count_i(p_cnt), .osc_pin_o(p_osc), .clk_pin_o(p_ck), .busy_o(p_busy));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic test_done();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic near(input logic [15:0] got, input int lo, input int hi);
    samples_checked++;
    if ($isunknown(got) || got < lo || got > hi) begin
      failures++;
      $display("[FAIL] %0t count %h outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // Classic single cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= 32'(d);
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat[7:0];
    cyc <= 0;
    stb <= 0;
    we <= 0;
    if (n >= 16) begin
      failures++;
      $display("[FAIL] %0t no bus answer", $time);
    end
  endtask
  task automatic rd_count();
    bus(0, LO, 8'h00);
    v[7:0] = q;
    bus(0, HI, 8'h00);
    v[15:8] = q;
  endtask
  task automatic wr_count(input logic [15:0] c);
    bus(1, LO, c[7:0]);
    bus(1, HI, c[15:8]);
  endtask
  task automatic pulses(input logic [5:0] n, input logic pick);
    int k;
    k = 0;
    @(posedge clk_i);
    p_pick <= pick;
    p_cnt <= n;
    p_start <= 1;
    @(posedge clk_i);
    p_start <= 0;
    // Busy rises at this edge; look one edge later
    @(posedge clk_i);
    while (p_busy !== 1'b0 && k < 900) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 900) begin
      failures++;
      $display("[FAIL] %0t pin burst hung", $time);
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    bus(0, CTL, 8'h00); check(q, 16'h0000);
    bus(0, PRT, 8'h00); check(q, 16'h0003);
    bus(0, 8'h3C, 8'h00); check(q, 16'h0000);
    bus(1, CTL, 8'hFF); bus(0, CTL, 8'h00); check(q, 16'h003F);
    bus(1, CTL, 8'h00);
    // Lane 0 off: the write is acked and dropped
    sel <= 4'h0;
    bus(1, LO, 8'hA5);
    sel <= 4'h1;
    bus(0, LO, 8'h00);
    check(q, 16'h0000);
    // Frozen count keeps random loads
    repeat (4) begin
      r = rnd();
      wr_count(r[15:0]);
      bus(1, CTL, r[23:16] & 8'h36);
      repeat (20) @(posedge clk_i);
      rd_count(); check(v, r[15:0]);
    end
    // Timer mode, every ratio, sync bit random
    for (int p = 0; p < 4; p++) begin
      r = rnd();
      wr_count(16'h0000);
      bus(1, CTL, {2'b00, p[1:0], 1'b0, r[0], 1'b0, 1'b1});
      repeat (256 << p) @(posedge clk_i);
      bus(1, CTL, 8'h00);
      rd_count(); near(v, 63, 66);
    end
    // Wrap through the maximum
    wr_count(16'hFFFE);
    bus(1, FLG, 8'h00); bus(1, IEN, 8'h01); bus(1, CTL, 8'h01);
    repeat (16) @(posedge clk_i);
    bus(1, CTL, 8'h00);
    rd_count(); near(v, 1, 5);
    bus(0, FLG, 8'h00); check(q, 16'h0001);
    repeat (2) @(posedge clk_i); check(irq, 1'b1);
    bus(1, IEN, 8'h00); repeat (2) @(posedge clk_i); check(irq, 1'b0);
    bus(0, FLG, 8'h00); check(q, 16'h0001);
    bus(1, FLG, 8'h00); bus(1, IEN, 8'h01);
    repeat (2) @(posedge clk_i); check(irq, 1'b0);
    // Compare-unit clear, never a flag
    for (int i = 1; i < 4; i++) begin
      wr_count(16'hFFFF);
      @(posedge clk_i) cmp <= i[1:0];
      @(posedge clk_i) cmp <= 2'h0;
      rd_count(); check(v, 16'h0000);
      bus(0, FLG, 8'h00); check(q, 16'h0000);
    end
    // Counter mode: both pins, sync on and off, idle pin ignored
    for (int m = 0; m < 4; m++) begin
      r = rnd();
      wr_count(16'h0000);
      bus(1, CTL, {2'b00, r[1:0], m[1], m[0], 1'b1, 1'b1});
      pulses(6'h03, ~m[1]);
      pulses(6'(4 << r[1:0]), m[1]);
      repeat (12) @(posedge clk_i);
      bus(1, CTL, 8'h00);
      rd_count(); check(v, 16'h0004);
    end
    // Port drive, then forced inputs
    bus(1, PRT, 8'h30); repeat (2) @(posedge clk_i);
    check({osc_oe_n, ck_oe_n, osc_o, ck_o}, 16'h0003);
    bus(1, CTL, 8'h08); repeat (2) @(posedge clk_i);
    check({osc_oe_n, ck_oe_n, run}, 16'h0007);
    bus(1, CTL, 8'h00); repeat (2) @(posedge clk_i);
    check({osc_oe_n, ck_oe_n, run}, 16'h0000);
    // Older-part software sets the clock pin's direction bit itself
    bus(1, PRT, 8'h32);
    bus(1, CTL, 8'h08);
    repeat (2) @(posedge clk_i);
    check({osc_oe_n, ck_oe_n}, 16'h0003);
    // Reset in mid-run puts every output back to idle
    rst_i <= 1;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    repeat (2) @(posedge clk_i);
    check({osc_oe_n, ck_oe_n, run, irq, ack}, 16'h0018);
    test_done();
  end

  // Whole run is near five thousand cycles; allow about six times that
  initial begin
    #150000;
    failures++;
    $display("[FAIL] %0t timeout", $time);
    test_done();
  end
endmodule

bind sixteen_bit_timer_counter timer_one_props #(.FORCE_BOTH_PINS(FORCE_BOTH_PINS)) i_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cmp_reset_i(cmp_reset_i),
  .osc_input_pin_i(osc_input_pin_i), .osc_input_pin_o(osc_input_pin_o),
  .osc_input_pin_oe_n_o(osc_input_pin_oe_n_o), .count_clock_pin_i(count_clock_pin_i),
  .count_clock_pin_o(count_clock_pin_o), .count_clock_pin_oe_n_o(count_clock_pin_oe_n_o),
  .osc_run_o(osc_run_o), .irq_o(irq_o));
`default_nettype wire

// file: sync_two_flop.sv
`timescale 1ns/100ps
`default_nettype none
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output var  logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // ==========================================================
  // First stage feeds only the second
  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end

endmodule
`default_nettype wire

// file: timer_one_pkg.sv
`default_nettype none
package timer_one_pkg;

  // ==========================================================
  // Register byte addresses on the 32-bit bus
  localparam logic [7:0] CONTROL_OFFSET    = 8'h10;
  localparam logic [7:0] COUNT_LOW_OFFSET  = 8'h14;
  localparam logic [7:0] COUNT_HIGH_OFFSET = 8'h18;
  localparam logic [7:0] FLAG_OFFSET       = 8'h1C;
  localparam logic [7:0] ENABLE_OFFSET     = 8'h20;
  localparam logic [7:0] PORT_OFFSET       = 8'h24;

  // ==========================================================
  // Control field positions
  localparam int CTL_ON_BIT   = 0;
  localparam int CTL_SRC_BIT  = 1;
  localparam int CTL_SYNC_BIT = 2;
  localparam int CTL_OSC_BIT  = 3;
  localparam int CTL_PS_LSB   = 4;
  localparam logic [7:0] CTL_IMPL_MASK = 8'h3F;

  // Flag, enable and port field positions
  localparam int FLAG_BIT     = 0;
  localparam int IRQEN_BIT    = 0;
  localparam int PORT_DIR_LSB = 0;
  localparam int PORT_OUT_LSB = 4;

  // ==========================================================
  // Values after reset, and the count maximum
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
  localparam logic [7:0]  PORT_RESET    = 8'h03;
  localparam logic [31:0] BUS_ZERO      = 32'h0000_0000;

  // ==========================================================
  // Last core clock of each four-clock instruction cycle; prescaler reset value
  localparam logic [1:0] INSTR_LAST = 2'h3;
  localparam logic [2:0] PRESC_RESET = 3'h0;

endpackage
`default_nettype wire

// file: timer_one_props.sv
`timescale 1ns/100ps
`default_nettype none
module timer_one_props #(
  parameter bit FORCE_BOTH_PINS = 1'b1
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [1:0]  cmp_reset_i,
  input wire logic        osc_input_pin_i,
  input wire logic        osc_input_pin_o,
  input wire logic        osc_input_pin_oe_n_o,
  input wire logic        count_clock_pin_i,
  input wire logic        count_clock_pin_o,
  input wire logic        count_clock_pin_oe_n_o,
  input wire logic        osc_run_o,
  input wire logic        irq_o
);
  // ==========================================================
  // Request decode seen from the pins
  logic take;
  logic wr_lo;
  assign take  = cyc_i && stb_i && !ack_o;
  assign wr_lo = take && we_i && sel_i[0];

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Bus answer
  property p_ack_once;
    ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held longer than one cycle");
  property p_ack_resp;
    take |=> ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("request not answered next cycle");
  property p_upper_zero;
    ack_o |-> dat_o[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data above byte not zero");
  property p_ctl_read;
    take && !we_i && adr_i == timer_one_pkg::CONTROL_OFFSET |=> dat_o[7:6] == 2'b00;
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control upper bits read nonzero");

  // ==========================================================
  // Oscillator and pin direction
  property p_osc_follow;
    wr_lo && adr_i == timer_one_pkg::CONTROL_OFFSET |-> ##2 osc_run_o == $past(dat_i[3], 2);
  endproperty
  a_osc_follow: assert property (p_osc_follow)
    else $error("oscillator run does not follow control");
  property p_osc_force;
    osc_run_o && $past(osc_run_o) |->
      osc_input_pin_oe_n_o && (count_clock_pin_oe_n_o || !FORCE_BOTH_PINS);
  endproperty
  a_osc_force: assert property (p_osc_force)
    else $error("pin driven while oscillator runs");
  property p_reset_quiet;
    $fell(rst_i) |-> !ack_o && !irq_o && !osc_run_o && osc_input_pin_oe_n_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not idle after reset");

  // ==========================================================
  // Interrupt request
  property p_irq_mask;
    wr_lo && adr_i == timer_one_pkg::ENABLE_OFFSET && !dat_i[0] |-> ##2 !irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("request passes with enable clear");
  // Flag only clears through a bus write, so a quiet bus keeps it
  property p_irq_hold;
    irq_o && !(cyc_i && stb_i) && !$past(cyc_i && stb_i) |=> irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("request dropped without software");
endmodule
`default_nettype wire
